// file: frag_cfg.svh
// Constants of the fragmented result handshake: byte offsets, codes, timing.
// Assumes inclusion by bare name from the design files.
`ifndef FRAG_CFG_SVH
`define FRAG_CFG_SVH

// ----------------------------------------------------------------
// Send and receive area layout (byte offsets)
// ----------------------------------------------------------------
`define AREA_BYTES      32
`define PKT_NUM_BYTE    1
`define LEN_LO_BYTE     2
`define LEN_HI_BYTE     3
`define DATA_ID_BYTE    4
`define PAYLOAD_FIRST   5
`define PAYLOAD_LAST    31
`define PAYLOAD_BYTES   27

// ----------------------------------------------------------------
// Codes
// ----------------------------------------------------------------
`define PKT_IDLE        8'h00
`define PKT_FIRST       8'h01
`define PKT_ABORT       8'hFF
`define ID_RESULT_ONLY  8'h81

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLOCK_MHZ       250
`define TICK_US         1000
`define TICK_CYCLES     (`TICK_US * `CLOCK_MHZ)

`endif

// file: frag_pkg.sv
// Types of the fragmented result handshake.
// Assumes frag_cfg.svh for the numeric constants.
package frag_pkg;

  typedef enum logic [2:0] {
    st_idle,
    st_load,
    st_wait_ack,
    st_close,
    st_abort
  } state_type;

  typedef enum logic [1:0] {
    err_none,
    err_timeout,
    err_order,
    err_peer_abort
  } err_type;

endpackage : frag_pkg

// file: result_ram.sv
// Byte memory holding one result string before it is sent.
// Assumes one writer and one reader on the same clock.
`timescale 1ns/10ps

module result_ram #(
  parameter int DEPTH = 1024,
  parameter int AW    = 10
) (
  // Clock
  input  wire logic          clock,
  // Write side
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [7:0]    wr_data,
  // Read side
  input  wire logic [AW-1:0] rd_addr,
  output logic      [7:0]    rd_data_q
);

  logic [7:0] mem [DEPTH];

  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clock) begin
    rd_data_q <= mem[rd_addr];
  end

endmodule : result_ram

// file: frag_sender.sv
// Reader end of the packet fragmentation handshake towards a cyclic controller.
// Assumes the send area is copied out and the receive area copied in cyclically.
`timescale 1ns/10ps
`include "frag_cfg.svh"

module frag_sender #(
  parameter int DEPTH       = 1024,
  parameter int AW          = 10,
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                         clock,
  input  wire logic                         resetn,
  // Result loading
  input  wire logic                         load_en,
  input  wire logic [AW-1:0]                load_addr,
  input  wire logic [7:0]                   load_data,
  input  wire logic                         start,
  input  wire logic [15:0]                  start_len,
  // Configuration
  input  wire logic [15:0]                  time_limit_ms,
  // Receive area from controller
  input  wire logic [7:0]                   recv_ack,
  input  wire logic [7:0]                   recv_data_id,
  // Send area to controller
  output logic      [7:0]                   send_pkt_num_q,
  output logic      [15:0]                  send_len_q,
  output logic      [8*`PAYLOAD_BYTES-1:0]  send_payload_q,
  // Status
  output logic                              busy_q,
  output logic                              done_q,
  output logic                              error_q,
  output frag_pkg::err_type                 err_code_q,
  output logic                              result_only_q
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  frag_pkg::state_type state_q;
  logic [15:0]         base_q;
  logic [15:0]         len_q;
  logic [4:0]          idx_q;
  logic [7:0]          prev_ack_q;
  logic [15:0]         ms_q;
  logic [31:0]         div_q;
  logic                tick;
  logic [7:0]          rd_data;
  logic [AW-1:0]       rd_addr;
  logic [15:0]         rd_pos;
  logic [15:0]         wr_pos;
  logic                last_pkt;
  logic                ack_new;
  logic                ack_cur;
  logic                ack_bad;
  logic                timed_out;
  logic                take_start;

  localparam logic [4:0]  PAY_N   = 5'(`PAYLOAD_BYTES);
  localparam logic [31:0] TICK_MX = 32'(TICK_CYCLES - 1);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign rd_pos     = base_q + 16'(idx_q);
  assign rd_addr    = rd_pos[AW-1:0];
  assign wr_pos     = rd_pos - 16'h0001;
  assign last_pkt   = (base_q + 16'(`PAYLOAD_BYTES)) >= len_q;
  assign ack_cur    = recv_ack == send_pkt_num_q;
  assign ack_new    = recv_ack != prev_ack_q;
  // Anything other than the shown number, the old one or an abort is out of order
  assign ack_bad    = ack_new && !ack_cur && recv_ack != `PKT_ABORT;
  assign timed_out  = time_limit_ms != 16'h0000 && ms_q > time_limit_ms;
  // Stay idle until the controller has let go of its previous byte 1
  assign take_start = start && recv_ack == `PKT_IDLE;

  result_ram #(
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_ram (
    .clock     (clock),
    .wr_en     (load_en && !busy_q),
    .wr_addr   (load_addr),
    .wr_data   (load_data),
    .rd_addr   (rd_addr),
    .rd_data_q (rd_data)
  );

  // ----------------------------------------------------------------
  // Millisecond tick and acknowledgement gap timer
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!resetn || div_q == TICK_MX) begin
      div_q <= 32'h00000000;
    end else begin
      div_q <= div_q + 32'h00000001;
    end
  end

  assign tick = div_q == TICK_MX;

  // Restarted on every fresh acknowledgement so only the gap is measured
  always_ff @(posedge clock) begin
    if (!resetn || state_q != frag_pkg::st_wait_ack || ack_new) begin
      ms_q <= 16'h0000;
    end else if (tick && ms_q != 16'hFFFF) begin
      ms_q <= ms_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Handshake sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_q        <= frag_pkg::st_idle;
      send_pkt_num_q <= `PKT_IDLE;
      send_len_q     <= 16'h0000;
      base_q         <= 16'h0000;
      len_q          <= 16'h0000;
      idx_q          <= 5'h00;
      prev_ack_q     <= `PKT_IDLE;
      done_q         <= 1'b0;
      error_q        <= 1'b0;
      err_code_q     <= frag_pkg::err_none;
    end else begin
      done_q  <= 1'b0;
      error_q <= 1'b0;
      unique case (state_q)
        frag_pkg::st_idle: begin
          send_pkt_num_q <= `PKT_IDLE;
          if (take_start) begin
            // Every result, even a single packet, goes the numbered way
            len_q      <= start_len;
            send_len_q <= start_len;
            base_q     <= 16'h0000;
            idx_q      <= 5'h00;
            prev_ack_q <= `PKT_IDLE;
            err_code_q <= frag_pkg::err_none;
            state_q    <= frag_pkg::st_load;
          end
        end
        frag_pkg::st_load: begin
          // One cycle of read latency, so the counter runs one past the last byte
          if (idx_q == PAY_N) begin
            idx_q          <= 5'h00;
            send_pkt_num_q <= send_pkt_num_q + 8'h01;
            state_q        <= frag_pkg::st_wait_ack;
          end else begin
            idx_q <= idx_q + 5'h01;
          end
        end
        frag_pkg::st_wait_ack: begin
          prev_ack_q <= recv_ack;
          if (recv_ack == `PKT_ABORT) begin
            send_pkt_num_q <= `PKT_IDLE;
            err_code_q     <= frag_pkg::err_peer_abort;
            error_q        <= 1'b1;
            state_q        <= frag_pkg::st_close;
          end else if (ack_bad || timed_out) begin
            send_pkt_num_q <= `PKT_ABORT;
            err_code_q     <= ack_bad ? frag_pkg::err_order : frag_pkg::err_timeout;
            error_q        <= 1'b1;
            state_q        <= frag_pkg::st_abort;
          end else if (ack_cur && ack_new) begin
            if (last_pkt) begin
              send_pkt_num_q <= `PKT_IDLE;
              send_len_q     <= 16'h0000;
              state_q        <= frag_pkg::st_close;
            end else begin
              base_q  <= base_q + 16'(`PAYLOAD_BYTES);
              state_q <= frag_pkg::st_load;
            end
          end
        end
        frag_pkg::st_close: begin
          // Controller ends the exchange by writing zero back
          send_pkt_num_q <= `PKT_IDLE;
          send_len_q     <= 16'h0000;
          if (recv_ack == `PKT_IDLE) begin
            done_q  <= err_code_q == frag_pkg::err_none;
            state_q <= frag_pkg::st_idle;
          end
        end
        frag_pkg::st_abort: begin
          // Hold the abort code until the controller has cleared its byte
          send_len_q <= 16'h0000;
          if (recv_ack == `PKT_IDLE) begin
            send_pkt_num_q <= `PKT_IDLE;
            state_q        <= frag_pkg::st_idle;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Payload bytes
  // ----------------------------------------------------------------
  // Only written while loading, which is after the previous number was acknowledged
  genvar b;
  generate
    for (b = 0; b < `PAYLOAD_BYTES; b++) begin : g_pay
      always_ff @(posedge clock) begin
        if (!resetn) begin
          send_payload_q[8*b +: 8] <= 8'h00;
        end else if (state_q == frag_pkg::st_load && idx_q == 5'(b + 1)) begin
          // Bytes past the net length read as zero
          send_payload_q[8*b +: 8] <= (wr_pos < len_q) ? rd_data : 8'h00;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Status
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!resetn) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= state_q != frag_pkg::st_idle || take_start;
    end
  end

  // Tells the result source whether only the plain string is wanted
  always_ff @(posedge clock) begin
    if (!resetn) begin
      result_only_q <= 1'b0;
    end else begin
      result_only_q <= recv_data_id == `ID_RESULT_ONLY;
    end
  end

endmodule : frag_sender

// file: frag_sender_properties.sv
// Checker of the reader end of the packet handshake, bound to frag_sender.
// Assumes frag_cfg.svh and frag_pkg are compiled before it.
`timescale 1ns/10ps
`include "frag_cfg.svh"

module frag_sender_properties (
  // Clock and reset
  input wire logic                        clock,
  input wire logic                        resetn,
  // Inputs
  input wire logic                        start,
  input wire logic [7:0]                  recv_ack,
  input wire logic [7:0]                  recv_data_id,
  // Send area and status
  input wire logic [7:0]                  send_pkt_num_q,
  input wire logic [15:0]                 send_len_q,
  input wire logic [8*`PAYLOAD_BYTES-1:0] send_payload_q,
  input wire logic                        busy_q,
  input wire logic                        done_q,
  input wire logic                        error_q,
  input wire frag_pkg::err_type           err_code_q,
  input wire logic                        result_only_q
);
  logic shown;
  logic last;
  assign shown = send_pkt_num_q != 8'h00 && send_pkt_num_q != 8'hFF;
  // Packet holds the tail of the result once 27 times its number reaches the length
  assign last = {8'h00, send_pkt_num_q} * 16'h001B >= send_len_q;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence s_take; start && !busy_q && recv_ack == 8'h00; endsequence
  sequence s_ack; shown && recv_ack == send_pkt_num_q; endsequence
  sequence s_new_ack; shown && recv_ack != $past(recv_ack); endsequence
  property p_first; s_take |=> busy_q ##[1:40] send_pkt_num_q == 8'h01; endproperty
  property p_stable;
    shown && recv_ack == send_pkt_num_q - 8'h01 |=>
      ($stable(send_payload_q) && $stable(send_len_q)) || send_pkt_num_q == 8'hFF;
  endproperty
  property p_next; s_ack ##0 !last |-> ##[1:40] send_pkt_num_q == recv_ack + 8'h01; endproperty
  property p_last;
    s_ack ##0 last |=> send_pkt_num_q == 8'h00 && send_len_q == 16'h0000;
  endproperty
  property p_order;
    s_new_ack ##0 (recv_ack != send_pkt_num_q && recv_ack != 8'hFF) |->
      ##[1:3] (send_pkt_num_q == 8'hFF && err_code_q == frag_pkg::err_order);
  endproperty
  property p_abort;
    s_new_ack ##0 recv_ack == 8'hFF |->
      ##[1:3] (error_q && err_code_q == frag_pkg::err_peer_abort);
  endproperty
  property p_hold_ff;
    send_pkt_num_q == 8'hFF && recv_ack != 8'h00 |=> send_pkt_num_q == 8'hFF;
  endproperty
  property p_done;
    done_q |-> (send_pkt_num_q == 8'h00 && send_len_q == 16'h0000) ##1 !done_q;
  endproperty
  property p_ident; 1'b1 |=> result_only_q == ($past(recv_data_id) == 8'h81); endproperty
  a_first: assert property (p_first) else $error("first packet missing");
  a_stable: assert property (p_stable) else $error("send area moved");
  a_next: assert property (p_next) else $error("next packet missing");
  a_last: assert property (p_last) else $error("close not shown");
  a_order: assert property (p_order) else $error("order error missed");
  a_abort: assert property (p_abort) else $error("peer abort missed");
  a_hold_ff: assert property (p_hold_ff) else $error("abort code dropped");
  a_done: assert property (p_done) else $error("bad done pulse");
  a_ident: assert property (p_ident) else $error("data id flag wrong");
endmodule : frag_sender_properties

bind frag_sender frag_sender_properties chk_u (.clock(clock), .resetn(resetn), .start(start),
  .recv_ack(recv_ack), .recv_data_id(recv_data_id), .send_pkt_num_q(send_pkt_num_q),
  .send_len_q(send_len_q), .send_payload_q(send_payload_q), .busy_q(busy_q), .done_q(done_q),
  .error_q(error_q), .err_code_q(err_code_q), .result_only_q(result_only_q));

// file: ctrl_model.sv
// Behavioural cyclic controller reading the send area and acknowledging.
// Assumes mode 0 good, 1 wrong ack, 2 abort, 3 silent; delay in cycles.
`timescale 1ns/10ps

module ctrl_model (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         resetn,
  // Send area
  input  wire logic [7:0]   send_pkt_num_q,
  input  wire logic [15:0]  send_len_q,
  input  wire logic [215:0] send_payload_q,
  // Behaviour
  input  wire logic [1:0]   mode,
  input  wire logic [7:0]   delay,
  // Receive area byte 1
  output logic      [7:0]   recv_ack
);
  logic [7:0]  rx_mem [0:255];
  logic [15:0] rx_len;
  logic [15:0] rx_count;
  logic [7:0]  seen;
  logic [7:0]  wait_n;
  always @(posedge clock) begin
    if (!resetn) begin
      recv_ack <= 8'h00;
      seen <= 8'h00;
      wait_n <= 8'h00;
    end else if (send_pkt_num_q == 8'h00 || send_pkt_num_q == 8'hFF) begin
      recv_ack <= 8'h00;
      seen <= 8'h00;
      wait_n <= 8'h00;
    end else if (send_pkt_num_q != seen && mode != 2'h3) begin
      if (wait_n < delay) begin
        wait_n <= wait_n + 8'h01;
      end else begin
        if (send_pkt_num_q == 8'h01) rx_len <= send_len_q;
        // Whole area taken in one edge, never split across updates
        for (int j = 0; j < 27; j++)
          rx_mem[(int'(send_pkt_num_q) - 1) * 27 + j] <=
            send_payload_q[8*j +: 8];
        rx_count <= 16'(send_pkt_num_q) * 16'h001B;
        seen <= send_pkt_num_q;
        wait_n <= 8'h00;
        recv_ack <= mode == 2'h1 ? send_pkt_num_q + 8'h01 :
                    mode == 2'h2 ? 8'hFF : send_pkt_num_q;
      end
    end
  end
endmodule : ctrl_model

// file: fragmented_result_handshake_tb.sv
// Self-checking bench of frag_sender against the controller model.
// Assumes ctrl_model and the bound checker are compiled before it.
`timescale 1ns/10ps

module fragmented_result_handshake_tb;
  logic              clock = 1'b0;
  logic              resetn = 1'b0;
  logic              load_en = 1'b0;
  logic [9:0]        load_addr = 10'h000;
  logic [7:0]        load_data = 8'h00;
  logic              start = 1'b0;
  logic [15:0]       start_len = 16'h0000;
  logic [15:0]       time_limit_ms = 16'h0008;
  logic [7:0]        recv_data_id = 8'h00;
  logic [1:0]        mode = 2'h0;
  logic [7:0]        delay = 8'h00;
  logic [7:0]        recv_ack, pkt_num;
  logic [15:0]       len;
  logic [215:0]      payload;
  logic              busy, done, error, result_only;
  frag_pkg::err_type code;
  int                err_count = 0;
  int                compares = 0;

  initial forever #2 clock = ~clock;

  frag_sender #(.TICK_CYCLES(10)) dut_u (.clock(clock), .resetn(resetn), .load_en(load_en),
    .load_addr(load_addr), .load_data(load_data), .start(start), .start_len(start_len),
    .time_limit_ms(time_limit_ms), .recv_ack(recv_ack), .recv_data_id(recv_data_id),
    .send_pkt_num_q(pkt_num), .send_len_q(len), .send_payload_q(payload), .busy_q(busy),
    .done_q(done), .error_q(error), .err_code_q(code), .result_only_q(result_only));
  ctrl_model ctl_u (.clock(clock), .resetn(resetn), .send_pkt_num_q(pkt_num), .send_len_q(len),
    .send_payload_q(payload), .mode(mode), .delay(delay), .recv_ack(recv_ack));

  function automatic logic [7:0] pat(input int i);
    return 8'(i) * 8'h05 + 8'h11;
  endfunction : pat

  task automatic check(input logic ok, input string what);
    compares++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("BAD %0t %s", $time, what);
    end
  endtask : check

  task automatic stop_test();
    $display("Compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test

  task automatic run(input logic [15:0] n, input logic [1:0] m, output logic got);
    int k;
    mode = m;
    start_len = n;
    start = 1'b1;
    @(negedge clock);
    start = 1'b0;
    for (k = 0; k < 3000; k++) begin
      @(negedge clock);
      if (done === 1'b1 || error === 1'b1) break;
    end
    if (k == 3000) begin
      err_count++;
      $display("BAD %0t transfer hung", $time);
      stop_test();
    end
    got = done;
    repeat (4) @(negedge clock);
  endtask : run

  task automatic t_good(input logic [15:0] n, input logic [7:0] d);
    logic got;
    int   nb;
    delay = d;
    run(n, 2'h0, got);
    nb = (n == 16'h0000) ? 27 : (int'(n) + 26) / 27 * 27;
    check(got === 1'b1, "no done");
    check(ctl_u.rx_len === n, "length");
    check(ctl_u.rx_count === 16'(nb), "packet count");
    for (int i = 0; i < nb; i++)
      check(ctl_u.rx_mem[i] === (i < n ? pat(i) : 8'h00), "payload byte");
    check(pkt_num === 8'h00 && len === 16'h0000 && busy === 1'b0, "not idle");
    $display("good transfer of %0d bytes done", n);
  endtask : t_good

  task automatic t_err(input logic [1:0] m, input logic [15:0] lim, input frag_pkg::err_type c);
    logic got;
    time_limit_ms = lim;
    run(16'h0014, m, got);
    check(got === 1'b0 && code === c, "error kind");
    check(pkt_num === 8'h00 && recv_ack === 8'h00, "no idle after abort");
    check(busy === 1'b0, "busy after abort");
    time_limit_ms = 16'h0008;
    $display("error case %0d done", m);
  endtask : t_err

  task automatic t_ident();
    recv_data_id = 8'h81;
    repeat (2) @(negedge clock);
    check(result_only === 1'b1, "id not seen");
    recv_data_id = 8'h00;
    repeat (2) @(negedge clock);
    check(result_only === 1'b0, "id stuck");
    $display("data id case done");
  endtask : t_ident

  initial begin
    repeat (6) @(negedge clock);
    resetn = 1'b1;
    // Buffer holds more than the short lengths, so the tail must read as zero
    load_en = 1'b1;
    for (int i = 0; i < 81; i++) begin
      load_addr = 10'(i);
      load_data = pat(i);
      @(negedge clock);
    end
    load_en = 1'b0;
    t_ident();
    t_good(16'h0014, 8'h00);
    t_good(16'h0036, 8'h05);
    t_good(16'h0037, 8'h00);
    t_good(16'h0000, 8'h02);
    t_err(2'h1, 16'h0008, frag_pkg::err_order);
    t_err(2'h2, 16'h0008, frag_pkg::err_peer_abort);
    t_err(2'h3, 16'h0002, frag_pkg::err_timeout);
    t_good(16'h0014, 8'h03);
    stop_test();
  end
endmodule : fragmented_result_handshake_tb
